//--- clamp_timing_cfg.svh
// Constants for the clamp pulse timing block: offsets, fields, resets, times.
// Assumes a 20 MHz pclk and a 12-bit APB byte address.
`ifndef CLAMP_TIMING_CFG_SVH
`define CLAMP_TIMING_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define OFFSET_REG_ADDR     12'h000
`define STATUS_REG_ADDR     12'h004
`define POSITION_MSB        6
`define POSITION_LSB        0
`define OFFSET_RESET        16'h0040

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS       50
`define SCLK_PERIOD_NS      82
`define PULSE_WIDTH_NS      1000
`define PULSE_CYCLES        ((`PULSE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_DELAY_NS        1300
`define MAX_DELAY_NS        10500
`define RESET_FILTER_CYCLES 5

`endif

//--- clamp_timing_pkg.sv
// Types shared by the clamp pulse timing block.
// Assumes nothing of its surroundings.
`default_nettype none
package clamp_timing_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DELAY = 3'b010,
    ST_PULSE = 3'b100
  } clamp_state_t;

  typedef struct packed {
    logic       core_reset_active;
    logic       pulse_active;
    logic       delay_active;
    logic [4:0] pulse_count;
  } clamp_status_t;

endpackage : clamp_timing_pkg
`default_nettype wire

//--- clamp_timing.sv
// Clamp pulse generator timed from the horizontal flyback edge, with an APB
// register slave and a filtered core reset.
// Assumes inputs synchronous to pclk and an APB master in the same domain.
`timescale 1ns/1ns
`default_nettype none
`include "clamp_timing_cfg.svh"

// How it works
// - Each flyback leading edge restarts delay timing.
// - Offset comes from bits six to zero.
// - Delay equals offset times 82 ns.
// - Pulse width fixed at one microsecond.
// - Pulse start held within 1.3 to 10.5 us.
// - Core reset needs pin low over five cycles.
module clamp_timing
  import clamp_timing_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        horizontal_flyback_pulse,
  input  wire logic        reset_pin_n,
  output var  logic        clamp_pulse,
  output var  logic        core_reset_n
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [15:0]   offset_reg;
  logic [31:0]   prdata_reg;
  logic [31:0]   prdata_next;
  logic          pready_reg;
  logic          pslverr_reg;
  logic          flyback_prev_reg;
  logic          flyback_rise;
  clamp_state_t  state_reg;
  clamp_state_t  state_next;
  logic [13:0]   elapsed_reg;
  logic [13:0]   target_ns;
  logic [13:0]   raw_ns;
  logic [4:0]    pulse_cnt_reg;
  logic          clamp_reg;
  logic [2:0]    low_cnt_reg;
  logic          core_reset_n_reg;
  logic          access;
  logic          mapped;
  clamp_status_t status;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // One wait state: pready rises at the edge that ends the first access
  // cycle and the transfer completes at the following edge.
  assign access = psel & penable & pready_reg;
  assign mapped = (paddr == `OFFSET_REG_ADDR) || (paddr == `STATUS_REG_ADDR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_reg <= `OFFSET_RESET;
    end else if (access && pwrite && paddr == `OFFSET_REG_ADDR) begin
      offset_reg <= pwdata[15:0];
    end
  end

  always_comb begin
    prdata_next = 32'h0000_0000;
    case (paddr)
      `OFFSET_REG_ADDR: prdata_next = {16'h0000, offset_reg};
      `STATUS_REG_ADDR: prdata_next = {24'h00_0000, status};
      default:          prdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && penable && !pready_reg && !pwrite) begin
      prdata_reg <= prdata_next;
    end
  end

  assign status = {~core_reset_n_reg,
                   clamp_reg,
                   (state_reg == ST_DELAY),
                   pulse_cnt_reg};

  // ****************************************************************
  // Clamp delay
  // ****************************************************************
  // The offset counts 82 ns steps; the count runs in nanoseconds so a
  // 50 ns clock reaches the step boundary without drifting.
  assign raw_ns = 14'(offset_reg[`POSITION_MSB:`POSITION_LSB]
                  * `SCLK_PERIOD_NS);

  always_comb begin
    if (raw_ns < 14'(`MIN_DELAY_NS)) begin
      target_ns = 14'(`MIN_DELAY_NS);
    end else if (raw_ns > 14'(`MAX_DELAY_NS)) begin
      target_ns = 14'(`MAX_DELAY_NS);
    end else begin
      target_ns = raw_ns;
    end
  end

  assign flyback_rise = horizontal_flyback_pulse & ~flyback_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flyback_prev_reg <= 1'b0;
    end else begin
      flyback_prev_reg <= horizontal_flyback_pulse;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (flyback_rise) begin
          state_next = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (flyback_rise) begin
          state_next = ST_DELAY;
        end else if (elapsed_reg >= target_ns) begin
          state_next = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (flyback_rise) begin
          state_next = ST_DELAY;
        end else if (pulse_cnt_reg == 5'(`PULSE_CYCLES - 1)) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_reg <= 14'h0000;
    end else if (flyback_rise) begin
      elapsed_reg <= 14'h0000;
    end else if (state_reg == ST_DELAY) begin
      elapsed_reg <= elapsed_reg + 14'(`CLK_PERIOD_NS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_reg <= 5'h00;
    end else if (state_reg == ST_PULSE && !flyback_rise) begin
      pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
    end else begin
      pulse_cnt_reg <= 5'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_reg <= 1'b0;
    end else begin
      clamp_reg <= (state_next == ST_PULSE);
    end
  end

  // ****************************************************************
  // Reset filter
  // ****************************************************************
  // Short glitches on the reset pin never reach the core.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_reg <= 3'h0;
    end else if (reset_pin_n) begin
      low_cnt_reg <= 3'h0;
    end else if (low_cnt_reg != 3'(`RESET_FILTER_CYCLES + 1)) begin
      low_cnt_reg <= low_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_n_reg <= 1'b1;
    end else if (reset_pin_n) begin
      core_reset_n_reg <= 1'b1;
    end else if (low_cnt_reg == 3'(`RESET_FILTER_CYCLES)) begin
      core_reset_n_reg <= 1'b0;
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign clamp_pulse  = clamp_reg;
  assign core_reset_n = core_reset_n_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence flyback_edge_s;
    horizontal_flyback_pulse && !flyback_prev_reg;
  endsequence

  sequence pin_low_s;
    !reset_pin_n [*6];
  endsequence

  edge_restarts_a: assert property (
    flyback_edge_s |=> state_reg == ST_DELAY && elapsed_reg == 14'h0000)
    else $error("flyback edge did not restart the delay");

  offset_write_a: assert property (
    access && pwrite && paddr == `OFFSET_REG_ADDR
    |=> offset_reg == $past(pwdata[15:0]))
    else $error("offset write not stored");

  start_time_a: assert property (
    state_reg == ST_DELAY && !flyback_rise && elapsed_reg >= target_ns
    |=> clamp_reg && state_reg == ST_PULSE)
    else $error("pulse did not start at the programmed delay");

  pulse_width_a: assert property (
    clamp_reg |-> pulse_cnt_reg < 5'(`PULSE_CYCLES))
    else $error("clamp pulse wider than one microsecond");

  start_range_a: assert property (
    $rose(clamp_reg) |-> $past(elapsed_reg) >= 14'(`MIN_DELAY_NS)
    && $past(elapsed_reg) <= 14'(`MAX_DELAY_NS + `CLK_PERIOD_NS))
    else $error("pulse start outside the allowed window");

  reset_filter_a: assert property (
    pin_low_s |=> !core_reset_n_reg)
    else $error("long reset pin low not passed to core");

  reset_short_a: assert property (
    reset_pin_n |=> core_reset_n_reg)
    else $error("core reset held with pin high");

  counter_start_a: assert property (
    $rose(clamp_reg) |-> $past(state_reg) == ST_DELAY)
    else $error("pulse began without a delay count");

endmodule : clamp_timing
`default_nettype wire

//--- flyback_source.sv
// Model of the deflection circuit that supplies the flyback pulse.
// Assumes a one-cycle trigger from the bench, synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module flyback_source #(
  parameter int WIDTH = 4
) (
  input  wire logic pclk,
  input  wire logic fire,
  output var  logic horizontal_flyback_pulse
);
  int left = 0;

  // Each trigger starts one clean high pulse of WIDTH cycles.
  always_ff @(posedge pclk) begin
    if (fire) begin
      left <= WIDTH;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end

  always_comb begin
    horizontal_flyback_pulse = (left > 0);
  end
endmodule : flyback_source
`default_nettype wire

//--- video_clamp_pulse_timing_tb.sv
// Self-checking bench for the clamp pulse timing block.
// Assumes the package, the design and flyback_source are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "clamp_timing_cfg.svh"
module video_clamp_pulse_timing_tb;
  import clamp_timing_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, flyback, clamp_pulse, core_reset_n, err;
  logic        reset_pin_n = 1, fire = 0;
  int          bad_count = 0, cmp_count = 0, k;
  logic [31:0] row_wr [4] = '{32'h0000_0000, 32'h1234_0010,
                              32'h0000_00c0, 32'h0000_ffff};

  clamp_timing u_clamp_timing (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .horizontal_flyback_pulse(flyback), .reset_pin_n(reset_pin_n),
    .clamp_pulse(clamp_pulse), .core_reset_n(core_reset_n));
  flyback_source u_flyback_source (.pclk(pclk), .fire(fire),
    .horizontal_flyback_pulse(flyback));

  // ************************************************
  // Tasks
  // ************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t no bus answer", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  // The count ignores a pulse still standing from an earlier flyback edge.
  task automatic fly(output int c);
    @(posedge pclk);
    fire <= 1;
    @(posedge pclk);
    fire <= 0;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (!(clamp_pulse === 1'b1 && c > 4) && c < 400);
  endtask : fly

  // The pulse rises ceil(delay/period)+2 cycles after the flyback rise and
  // is first sampled high at the edge after that.
  function automatic int dly(input int pos);
    int t;
    t = pos * `SCLK_PERIOD_NS;
    if (t < `MIN_DELAY_NS) t = `MIN_DELAY_NS;
    if (t > `MAX_DELAY_NS) t = `MAX_DELAY_NS;
    return (t + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 3;
  endfunction : dly

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // ************************************************
  // Stimulus
  // ************************************************
  initial begin
    forever #25 pclk = ~pclk;
  end

  initial begin
    #(20000 * 50);
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, `OFFSET_REG_ADDR, 0);
    chk(rd, {16'h0000, `OFFSET_RESET});
    apb(1, `STATUS_REG_ADDR, 32'hffff_ffff);
    apb(0, `STATUS_REG_ADDR, 0);
    chk(rd, 32'h0000_0000);
    apb(0, 12'h008, 0);
    chk({rd[30:0], err}, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      apb(1, `OFFSET_REG_ADDR, row_wr[i]);
      apb(0, `OFFSET_REG_ADDR, 0);
      chk(rd, row_wr[i] & 32'h0000_ffff);
      fly(k);
      chk(k, dly(row_wr[i][6:0]));
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (clamp_pulse === 1'b1 && k < 100);
      chk(k, `PULSE_CYCLES);
    end
    fly(k);
    repeat (5) @(posedge pclk);
    fly(k);
    chk(k, dly(127));
    reset_pin_n <= 0;
    repeat (5) begin
      @(posedge pclk);
      chk(core_reset_n, 1);
    end
    reset_pin_n <= 1;
    repeat (3) @(posedge pclk);
    chk(core_reset_n, 1);
    reset_pin_n <= 0;
    repeat (10) @(posedge pclk);
    chk(core_reset_n, 0);
    reset_pin_n <= 1;
    repeat (3) @(posedge pclk);
    chk(core_reset_n, 1);
    fly(k);
    chk(k, dly(127));
    presetn <= 0;
    @(posedge pclk);
    chk({pready, pslverr, clamp_pulse, core_reset_n}, 32'h0000_0001);
    chk(prdata, 32'h0000_0000);
    presetn <= 1;
    repeat (2) begin
      @(posedge pclk);
      chk({pready, pslverr, clamp_pulse, core_reset_n}, 32'h0000_0001);
    end
    apb(0, `OFFSET_REG_ADDR, 0);
    chk(rd, {16'h0000, `OFFSET_RESET});
    end_sim();
  end
endmodule : video_clamp_pulse_timing_tb
`default_nettype wire
